// ==== pin_partner.sv ====
// partner: external devices and pull-ups on the bidirectional pins
// assumes push-pull drive from the port block
`default_nettype none
module pin_partner (
  input wire logic pclk,
  input wire logic [11:0] pin_o,
  input wire logic [11:0] pin_oe,
  input wire logic [11:0] pullup_en,
  input wire logic [11:0] ext_en,
  input wire logic [11:0] ext_val,
  output logic [11:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] wander_reg = 12'h5a5;
  always @(posedge pclk) wander_reg <= ~wander_reg;
  // ==========================================================================
  // wire level: port, then outside driver, then pull-up, else wandering
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (pin_oe[i]) pin_i[i] = pin_o[i];
      else if (ext_en[i]) pin_i[i] = ext_val[i];
      else if (pullup_en[i]) pin_i[i] = 1'b1;
      else pin_i[i] = wander_reg[i];
    end
  end
endmodule
`default_nettype wire

// ==== port_sfmux_asserts.sv ====
// checker: pin and bus relations of the port special-function mux
// assumes default build parameters (all push-pull), bound to the top module
`default_nettype none
module port_sfmux_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic out_bit2_float,
  input wire logic out_bit3_float,
  input wire logic out_bit3_data,
  input wire logic out_bit2_pin_oe,
  input wire logic out_bit3_pin_oe,
  input wire logic out_bit3_pin_o,
  input wire logic serial_select,
  input wire logic serial_slave,
  input wire logic serial_data_out,
  input wire logic serial_clock_o,
  input wire logic serial_ready_out,
  input wire logic [11:0] bidir_pin_o,
  input wire logic [11:0] bidir_pin_oe,
  input wire logic [11:0] bidir_pullup_en
);
  // ==========================================================================
  // pin and bus relations
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_float_hiz: assert property (out_bit3_float |=> !out_bit3_pin_oe)
    else $error("floated bit3 still driven");
  a_float_drive: assert property (!out_bit2_float |=> out_bit2_pin_oe)
    else $error("bit2 not driven");
  a_zero_low: assert property (!out_bit3_data |=> !out_bit3_pin_o)
    else $error("bit3 not low with data 0");
  a_pullup_input: assert property ((bidir_pullup_en & bidir_pin_oe) == 12'h0)
    else $error("pull-up on a driven bit");
  a_master_clock: assert property (serial_select && !serial_slave |=>
    bidir_pin_oe[6] && bidir_pin_o[6] == $past(serial_clock_o))
    else $error("master clock not on pin");
  a_serial_out: assert property (serial_select |=>
    bidir_pin_oe[5] && bidir_pin_o[5] == $past(serial_data_out))
    else $error("serial data not on pin");
  a_slave_ready: assert property (serial_select && serial_slave |=>
    bidir_pin_oe[7] && !bidir_pin_oe[6] && bidir_pin_o[7] == $past(serial_ready_out))
    else $error("slave pins wrong");
  a_serial_in: assert property (serial_select |=> !bidir_pin_oe[4])
    else $error("serial input driven");
  a_reset_input: assert property ($rose(presetn) |-> bidir_pin_oe == 12'h0)
    else $error("driven after reset");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
endmodule
bind port_special_function_mux port_sfmux_asserts chk_u (.pclk, .presetn, .psel, .penable,
  .pslverr, .out_bit2_float, .out_bit3_float, .out_bit3_data, .out_bit2_pin_oe,
  .out_bit3_pin_oe, .out_bit3_pin_o, .serial_select, .serial_slave, .serial_data_out,
  .serial_clock_o, .serial_ready_out, .bidir_pin_o, .bidir_pin_oe, .bidir_pullup_en);
`default_nettype wire

// ==== port_sfmux_pkg.sv ====
// constants for the port special-function mux: register indices, fields, reset values, timing
// assumes registers are reached over apb with 32-bit data, one word per register index
`default_nettype none
package port_sfmux_pkg;
  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [15:0] CLKOUT_CTRL_IDX = 16'hff06;
  localparam logic [15:0] TIMER_OUT_IDX = 16'hffc1;
  localparam logic [15:0] DIR0_IDX = 16'hff40;
  localparam logic [15:0] PUL0_IDX = 16'hff41;
  localparam logic [15:0] DAT0_IDX = 16'hff42;
  localparam logic [15:0] DIR1_IDX = 16'hff44;
  localparam logic [15:0] PUL1_IDX = 16'hff45;
  localparam logic [15:0] DAT1_IDX = 16'hff46;
  localparam logic [15:0] DIR2_IDX = 16'hff48;
  localparam logic [15:0] PUL2_IDX = 16'hff49;
  localparam logic [15:0] DAT2_IDX = 16'hff4a;
  localparam logic [15:0] LCD_CTRL_IDX = 16'hff61;
  localparam int ADDR_W = 18;
  // ==========================================================================
  // field positions
  localparam int FREQ_SEL_LSB = 0;
  localparam int CLKOUT_EN_BIT = 3;
  localparam int TIMER_OUT_EN_BIT = 2;
  localparam int LCD_SEL_BIT = 3;
  // ==========================================================================
  // reset values
  localparam logic [1:0] FREQ_SEL_RST = 2'h0;
  localparam logic [3:0] DIR_RST = 4'h0;
  localparam logic [3:0] PUL_RST = 4'hf;
  localparam logic [3:0] DAT_RST = 4'h0;
  // ==========================================================================
  // clock-out frequency select codes
  localparam logic [1:0] FSEL_FAST = 2'h3;
  localparam logic [1:0] FSEL_SLOW = 2'h2;
  localparam logic [1:0] FSEL_DIV8 = 2'h1;
  localparam logic [1:0] FSEL_DIV64 = 2'h0;
  localparam int DIV8_BIT = 2;
  localparam int DIV64_BIT = 5;
  // ==========================================================================
  // lcd duty codes, line half-period minus one in slow-clock rising edges, frame half-period minus one in line-sync periods
  localparam logic [1:0] DUTY_8 = 2'h0;
  localparam logic [1:0] DUTY_16 = 2'h1;
  localparam logic [1:0] DUTY_17 = 2'h2;
  localparam logic [4:0] LINE_HALF_DUTY8 = 5'h1f;
  localparam logic [4:0] LINE_HALF_DUTY16 = 5'h0f;
  localparam logic [4:0] FRAME_LINES_8 = 5'h07;
  localparam logic [4:0] FRAME_LINES_16 = 5'h0f;
  localparam logic [4:0] FRAME_LINES_17 = 5'h10;
endpackage
`default_nettype wire

// ==== port_special_function_mux.sv ====
// port logic: clock-out and timer-out on two output bits, twelve bidirectional bits
// assumes oscillator and timer clocks arrive asynchronous, output-port registers on pclk
//
// What this block does
// [R1] clock-out enable drives clock-out on output bit 3
// [R2] frequency select picks fast, slow, /8, /64
// [R3] timer-out enable drives timer clock on bit 2
// [R4] data 0 holds special pin low
// [R5] float control floats special pin anyway
// [R6] software keeps data 1, float 0 for specials
// [R7] software starts fast oscillator before selecting it
// [R8] group1 serial, group2 bits 2-3 lcd sync
// [R9] serial pin roles depend on master or slave
// [R10] direction bit: 0 input floats, 1 drives data
// [R11] read returns register in output, pin in input
// [R12] direction bits reset to input mode
// [R13] direction bits of special bits are storage
// [R14] pull-up only in input mode with control 1
// [R15] pull-up storage for outputs, live for serial inputs
// [R16] lcd select puts line sync, frame on pins
// [R17] line sync 512 or 1024 Hz per duty
// [R18] build options: push-pull or open-drain, pull-up presence; group 1 uses only parameter bit 0, group 0 is fixed push-pull with pull-up
// [R19] frame 32 Hz, or 30.12 Hz at 1/17 duty
// [R20] timer-out passes programmable timer clock to pin
// [R21] build options are parameters, not registers
//
// Added by the designer: the APB interface to the registers.
`default_nettype none
module port_special_function_mux #(
  parameter logic [3:0] group1_open_drain = 4'h0,
  parameter logic [3:0] group2_open_drain = 4'h0,
  parameter logic [3:0] group1_pullup_fitted = 4'hf,
  parameter logic [3:0] group2_pullup_fitted = 4'hf
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_osc_clock,
  input wire logic fast_osc_clock,
  input wire logic timer_clock_out,
  input wire logic out_bit2_data,
  input wire logic out_bit3_data,
  input wire logic out_bit2_float,
  input wire logic out_bit3_float,
  output logic out_bit2_pin_o,
  output logic out_bit2_pin_oe,
  output logic out_bit3_pin_o,
  output logic out_bit3_pin_oe,
  input wire logic serial_select,
  input wire logic serial_slave,
  input wire logic serial_data_out,
  input wire logic serial_clock_o,
  input wire logic serial_ready_out,
  output logic serial_data_in,
  output logic serial_clock_i,
  input wire logic [1:0] lcd_duty,
  input wire logic [11:0] bidir_pin_i,
  output logic [11:0] bidir_pin_o,
  output logic [11:0] bidir_pin_oe,
  output logic [11:0] bidir_pullup_en,
  output logic clkout_signal,
  output logic lcd_line_sync,
  output logic lcd_frame_signal
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0] freq_sel;
    logic clkout_enable;
    logic timer_out_enable;
    logic lcd_sync_out_select;
    logic [11:0] dir;
    logic [11:0] pul;
    logic [11:0] dat;
    logic [11:0] pin_meta;
    logic [11:0] pin_sync;
    logic [2:0] clk_meta;
    logic [2:0] clk_sync;
    logic slow_prev;
    logic [5:0] slow_div;
    logic clkout;
    logic [4:0] line_cnt;
    logic line_sig;
    logic [4:0] frame_cnt;
    logic frame_sig;
    logic [11:0] pin_o;
    logic [11:0] pin_oe;
    logic [11:0] pu;
    logic b2_o;
    logic b2_oe;
    logic b3_o;
    logic b3_oe;
    logic ser_din;
    logic ser_clk;
    logic [31:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{
    freq_sel: port_sfmux_pkg::FREQ_SEL_RST,
    clkout_enable: 1'b0,
    timer_out_enable: 1'b0,
    lcd_sync_out_select: 1'b0,
    dir: {3{port_sfmux_pkg::DIR_RST}},
    pul: {3{port_sfmux_pkg::PUL_RST}},
    dat: {3{port_sfmux_pkg::DAT_RST}},
    pin_meta: 12'h000,
    pin_sync: 12'h000,
    clk_meta: 3'h0,
    clk_sync: 3'h0,
    slow_prev: 1'b0,
    slow_div: 6'h00,
    clkout: 1'b0,
    line_cnt: 5'h00,
    line_sig: 1'b0,
    frame_cnt: 5'h00,
    frame_sig: 1'b0,
    pin_o: 12'h000,
    pin_oe: 12'h000,
    pu: 12'h000,
    b2_o: 1'b1,
    b2_oe: 1'b1,
    b3_o: 1'b1,
    b3_oe: 1'b1,
    ser_din: 1'b0,
    ser_clk: 1'b0,
    rdata: 32'h0000_0000
  };

  state_t state_reg;
  state_t state_next;

  // ==========================================================================
  // helpers
  function automatic logic [17:0] word_addr(input logic [15:0] idx);
    word_addr = {idx, 2'b00};
  endfunction

  // output-mode bits show the register, input-mode bits the pin
  function automatic logic [3:0] port_read(input logic [3:0] d, input logic [3:0] dat,
                                           input logic [3:0] pin);
    port_read = (d & dat) | (~d & pin); // R11
  endfunction

  // drive a pin: open-drain bits only pull low
  function automatic logic [1:0] drive(input logic val, input logic od);
    drive = {val, od ? ~val : 1'b1}; // R18
  endfunction

  // ==========================================================================
  // next state
  logic wr;
  logic hit;
  logic [31:0] rd;
  logic [11:0] fn_out;
  logic [11:0] fn_in;
  logic [11:0] fn_val;
  logic [11:0] od;
  logic [11:0] fitted;
  logic slow_rise;
  logic line_rise;
  logic clkout_signal_src;
  logic [4:0] line_half;
  logic [4:0] frame_lines;
  logic [1:0] dv;

  always_comb begin
    state_next = state_reg;
    wr = psel & penable & pwrite;
    hit = 1'b1;
    rd = 32'h0000_0000;
    fn_out = 12'h000;
    fn_in = 12'h000;
    fn_val = 12'h000;
    od = {group2_open_drain, {4{group1_open_drain[0]}}, 4'h0}; // R18 R21
    fitted = {group2_pullup_fitted, {4{group1_pullup_fitted[0]}}, 4'hf}; // R18 R21
    dv = 2'h0;
    // synchronisers
    state_next.pin_meta = bidir_pin_i;
    state_next.pin_sync = state_reg.pin_meta;
    state_next.clk_meta = {timer_clock_out, fast_osc_clock, slow_osc_clock};
    state_next.clk_sync = state_reg.clk_meta;
    state_next.slow_prev = state_reg.clk_sync[0];
    slow_rise = state_reg.clk_sync[0] & ~state_reg.slow_prev;
    // register decode
    unique case (paddr)
      word_addr(port_sfmux_pkg::CLKOUT_CTRL_IDX): begin
        rd[port_sfmux_pkg::CLKOUT_EN_BIT] = state_reg.clkout_enable;
        rd[port_sfmux_pkg::FREQ_SEL_LSB +: 2] = state_reg.freq_sel;
        if (wr) begin
          state_next.clkout_enable = pwdata[port_sfmux_pkg::CLKOUT_EN_BIT];
          state_next.freq_sel = pwdata[port_sfmux_pkg::FREQ_SEL_LSB +: 2]; // R2
        end
      end
      word_addr(port_sfmux_pkg::TIMER_OUT_IDX): begin
        rd[port_sfmux_pkg::TIMER_OUT_EN_BIT] = state_reg.timer_out_enable;
        if (wr) begin
          state_next.timer_out_enable = pwdata[port_sfmux_pkg::TIMER_OUT_EN_BIT];
        end
      end
      word_addr(port_sfmux_pkg::LCD_CTRL_IDX): begin
        rd[port_sfmux_pkg::LCD_SEL_BIT] = state_reg.lcd_sync_out_select;
        if (wr) begin
          state_next.lcd_sync_out_select = pwdata[port_sfmux_pkg::LCD_SEL_BIT];
        end
      end
      word_addr(port_sfmux_pkg::DIR0_IDX): begin
        rd[3:0] = state_reg.dir[3:0];
        if (wr) begin
          state_next.dir[3:0] = pwdata[3:0]; // R13
        end
      end
      word_addr(port_sfmux_pkg::DIR1_IDX): begin
        rd[3:0] = state_reg.dir[7:4];
        if (wr) begin
          state_next.dir[7:4] = pwdata[3:0]; // R13
        end
      end
      word_addr(port_sfmux_pkg::DIR2_IDX): begin
        rd[3:0] = state_reg.dir[11:8];
        if (wr) begin
          state_next.dir[11:8] = pwdata[3:0]; // R13
        end
      end
      word_addr(port_sfmux_pkg::PUL0_IDX): begin
        rd[3:0] = state_reg.pul[3:0];
        if (wr) begin
          state_next.pul[3:0] = pwdata[3:0]; // R15
        end
      end
      word_addr(port_sfmux_pkg::PUL1_IDX): begin
        rd[3:0] = state_reg.pul[7:4];
        if (wr) begin
          state_next.pul[7:4] = pwdata[3:0]; // R15
        end
      end
      word_addr(port_sfmux_pkg::PUL2_IDX): begin
        rd[3:0] = state_reg.pul[11:8];
        if (wr) begin
          state_next.pul[11:8] = pwdata[3:0]; // R15
        end
      end
      word_addr(port_sfmux_pkg::DAT0_IDX): begin
        rd[3:0] = port_read(state_reg.dir[3:0], state_reg.dat[3:0], state_reg.pin_sync[3:0]);
        if (wr) begin
          state_next.dat[3:0] = pwdata[3:0];
        end
      end
      word_addr(port_sfmux_pkg::DAT1_IDX): begin
        rd[3:0] = port_read(state_reg.dir[7:4], state_reg.dat[7:4], state_reg.pin_sync[7:4]);
        if (wr) begin
          state_next.dat[7:4] = pwdata[3:0];
        end
      end
      word_addr(port_sfmux_pkg::DAT2_IDX): begin
        rd[3:0] = port_read(state_reg.dir[11:8], state_reg.dat[11:8],
                            state_reg.pin_sync[11:8]);
        if (wr) begin
          state_next.dat[11:8] = pwdata[3:0];
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (psel & ~penable) begin
      state_next.rdata = rd;
    end
    // ========================================================================
    // clock-out source
    if (slow_rise) begin
      state_next.slow_div = state_reg.slow_div + 6'h01;
    end
    unique case (state_reg.freq_sel) // R2
      port_sfmux_pkg::FSEL_FAST: clkout_signal_src = state_reg.clk_sync[1];
      port_sfmux_pkg::FSEL_SLOW: clkout_signal_src = state_reg.clk_sync[0];
      port_sfmux_pkg::FSEL_DIV8: clkout_signal_src = state_reg.slow_div[port_sfmux_pkg::DIV8_BIT];
      port_sfmux_pkg::FSEL_DIV64: clkout_signal_src = state_reg.slow_div[port_sfmux_pkg::DIV64_BIT];
    endcase
    state_next.clkout = state_reg.clkout_enable ? clkout_signal_src : 1'b1; // R1
    // ========================================================================
    // lcd line sync and frame
    line_half = (lcd_duty == port_sfmux_pkg::DUTY_8) ? port_sfmux_pkg::LINE_HALF_DUTY8
                                                      : port_sfmux_pkg::LINE_HALF_DUTY16;
    unique case (lcd_duty)
      port_sfmux_pkg::DUTY_16: frame_lines = port_sfmux_pkg::FRAME_LINES_16;
      port_sfmux_pkg::DUTY_17: frame_lines = port_sfmux_pkg::FRAME_LINES_17;
      default: frame_lines = port_sfmux_pkg::FRAME_LINES_8;
    endcase
    line_rise = 1'b0;
    if (slow_rise) begin
      if (state_reg.line_cnt >= line_half) begin // R17
        state_next.line_cnt = 5'h00;
        state_next.line_sig = ~state_reg.line_sig;
        line_rise = ~state_reg.line_sig;
      end else begin
        state_next.line_cnt = state_reg.line_cnt + 5'h01;
      end
    end
    if (line_rise) begin
      if (state_reg.frame_cnt >= frame_lines) begin // R19
        state_next.frame_cnt = 5'h00;
        state_next.frame_sig = ~state_reg.frame_sig;
      end else begin
        state_next.frame_cnt = state_reg.frame_cnt + 5'h01;
      end
    end
    // ========================================================================
    // special output bits 2 and 3
    state_next.b2_oe = ~out_bit2_float; // R5
    state_next.b3_oe = ~out_bit3_float; // R5
    state_next.b2_o = out_bit2_data & (state_reg.timer_out_enable ? // R4
                                       state_reg.clk_sync[2] : 1'b1); // R3 R20
    state_next.b3_o = out_bit3_data & (state_reg.clkout_enable ? state_reg.clkout : 1'b1); // R1 R4
    // ========================================================================
    // bidirectional function assignment
    if (serial_select) begin // R8 R9
      fn_in[4] = 1'b1;
      fn_out[5] = 1'b1;
      fn_val[5] = serial_data_out;
      if (serial_slave) begin
        fn_in[6] = 1'b1;
        fn_out[7] = 1'b1;
        fn_val[7] = serial_ready_out;
      end else begin
        fn_out[6] = 1'b1;
        fn_val[6] = serial_clock_o;
      end
    end
    if (state_reg.lcd_sync_out_select) begin // R16
      fn_out[11:10] = 2'h3;
      fn_val[10] = state_reg.line_sig;
      fn_val[11] = state_reg.frame_sig;
    end
    for (int i = 0; i < 12; i++) begin
      if (fn_out[i]) begin
        dv = drive(fn_val[i], od[i]);
        state_next.pu[i] = 1'b0; // R15
      end else if (fn_in[i]) begin
        dv = 2'h0;
        state_next.pu[i] = state_reg.pul[i] & fitted[i]; // R15
      end else begin
        dv = drive(state_reg.dat[i], od[i]) & {2{state_reg.dir[i]}}; // R10 R12
        state_next.pu[i] = ~state_reg.dir[i] & state_reg.pul[i] & fitted[i]; // R14
      end
      state_next.pin_o[i] = dv[1];
      state_next.pin_oe[i] = dv[0];
    end
    state_next.ser_din = state_reg.pin_sync[4]; // R9
    state_next.ser_clk = state_reg.pin_sync[6]; // R9
  end

  // ==========================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = state_reg.rdata;
  assign out_bit2_pin_o = state_reg.b2_o;
  assign out_bit2_pin_oe = state_reg.b2_oe;
  assign out_bit3_pin_o = state_reg.b3_o;
  assign out_bit3_pin_oe = state_reg.b3_oe;
  assign bidir_pin_o = state_reg.pin_o;
  assign bidir_pin_oe = state_reg.pin_oe;
  assign bidir_pullup_en = state_reg.pu;
  assign serial_data_in = state_reg.ser_din;
  assign serial_clock_i = state_reg.ser_clk;
  assign clkout_signal = state_reg.clkout;
  assign lcd_line_sync = state_reg.line_sig;
  assign lcd_frame_signal = state_reg.frame_sig;

endmodule
`default_nettype wire

// ==== testbench.sv ====
// testbench: registers over apb, special outputs, serial and lcd pin sharing
// assumes the partner model resolves the bidirectional pins
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam real SLOW = 20.2;
  localparam real FAST = 14.2;
  localparam real TMR = 24.2;
  localparam int W = 2560;
  typedef struct packed {logic [15:0] idx; logic [3:0] wd, ex, rs;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic slow_osc_clock = 0, fast_osc_clock = 0, timer_clock_out = 0;
  logic out_bit2_data = 1, out_bit3_data = 1, out_bit2_float = 0, out_bit3_float = 0;
  logic serial_select = 0, serial_slave = 0, serial_data_out = 0, serial_clock_o = 0;
  logic serial_ready_out = 0, serial_data_in, serial_clock_i;
  logic [1:0] lcd_duty = 0;
  logic [11:0] bidir_pin_i, bidir_pin_o, bidir_pin_oe, bidir_pullup_en;
  logic [11:0] ext_en = '0, ext_val = '0;
  logic out_bit2_pin_o, out_bit2_pin_oe, out_bit3_pin_o, out_bit3_pin_oe;
  logic clkout_signal, lcd_line_sync, lcd_frame_signal;
  int mismatches = 0, n_checks = 0, cyc = 0, n, lh, fl;
  real per[4] = '{SLOW * 64, SLOW * 8, SLOW, FAST};
  row_t rows[9] = '{
    '{port_sfmux_pkg::DIR0_IDX, 4'h5, 4'h5, 4'h0},
    '{port_sfmux_pkg::PUL0_IDX, 4'ha, 4'ha, 4'hf},
    '{port_sfmux_pkg::DIR1_IDX, 4'hf, 4'hf, 4'h0},
    '{port_sfmux_pkg::PUL1_IDX, 4'h6, 4'h6, 4'hf},
    '{port_sfmux_pkg::DIR2_IDX, 4'hc, 4'hc, 4'h0},
    '{port_sfmux_pkg::PUL2_IDX, 4'h3, 4'h3, 4'hf},
    '{port_sfmux_pkg::CLKOUT_CTRL_IDX, 4'hf, 4'hb, 4'h0},
    '{port_sfmux_pkg::TIMER_OUT_IDX, 4'hf, 4'h4, 4'h0},
    '{port_sfmux_pkg::LCD_CTRL_IDX, 4'h8, 4'h8, 4'h0}};
  port_special_function_mux dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .slow_osc_clock, .fast_osc_clock, .timer_clock_out,
    .out_bit2_data, .out_bit3_data, .out_bit2_float, .out_bit3_float, .out_bit2_pin_o,
    .out_bit2_pin_oe, .out_bit3_pin_o, .out_bit3_pin_oe, .serial_select, .serial_slave,
    .serial_data_out, .serial_clock_o, .serial_ready_out, .serial_data_in, .serial_clock_i,
    .lcd_duty, .bidir_pin_i, .bidir_pin_o, .bidir_pin_oe, .bidir_pullup_en, .clkout_signal,
    .lcd_line_sync, .lcd_frame_signal);
  pin_partner part_u (.pclk, .pin_o(bidir_pin_o), .pin_oe(bidir_pin_oe),
    .pullup_en(bidir_pullup_en), .ext_en, .ext_val, .pin_i(bidir_pin_i));
  // ==========================================================================
  // clocks, timeout and helpers
  initial forever #2 pclk = ~pclk;
  initial forever #(SLOW / 2) slow_osc_clock = ~slow_osc_clock;
  initial forever #(FAST / 2) fast_osc_clock = ~fast_osc_clock;
  initial forever #(TMR / 2) timer_clock_out = ~timer_clock_out;
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 60000) begin
      mismatches++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic near(input int g, input int e, input int t);
    chk(32'(g >= e - t && g <= e + t), 32'h1);
  endtask
  task automatic apb(input logic [15:0] i, input logic w, input logic [3:0] d,
      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {28'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] i, input logic [3:0] d);
    apb(i, 1'b1, d, rd, er);
  endtask
  task automatic rc(input logic [15:0] i, input logic [3:0] e);
    apb(i, 1'b0, 4'h0, rd, er);
    chk(rd, {28'h0, e});
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return clkout_signal;
      1: return out_bit2_pin_o;
      2: return lcd_line_sync;
      3: return lcd_frame_signal;
      default: return out_bit3_pin_o;
    endcase
  endfunction
  task automatic rises(input int s, input int w, output int c);
    logic p;
    c = 0;
    p = sig(s);
    repeat (w) begin
      @(posedge pclk);
      if (sig(s) && !p) c++;
      p = sig(s);
    end
  endtask
  task automatic half(input int s, output int c);
    logic p;
    repeat (2) begin
      p = sig(s);
      c = 0;
      while (sig(s) === p && c < 6000) begin
        @(posedge pclk);
        c++;
      end
    end
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rc(rows[i].idx, rows[i].ex);
    end
    wr(port_sfmux_pkg::DIR0_IDX, 4'hf);
    wr(port_sfmux_pkg::DAT0_IDX, 4'h6);
    repeat (3) @(posedge pclk);
    chk(32'({bidir_pin_oe[3:0], bidir_pin_o[3:0], bidir_pullup_en[3:0]}), 32'hf60);
    rc(port_sfmux_pkg::DAT0_IDX, 4'h6);
    ext_en <= 12'h00f;
    ext_val <= 12'h005;
    wr(port_sfmux_pkg::DIR0_IDX, 4'h0);
    wr(port_sfmux_pkg::PUL0_IDX, 4'h3);
    rc(port_sfmux_pkg::DAT0_IDX, 4'h5);
    chk(32'({bidir_pin_oe[3:0], bidir_pullup_en[3:0]}), 32'h03);
    ext_en <= 12'h0;
    wr(port_sfmux_pkg::PUL0_IDX, 4'hf);
    repeat (5) @(posedge pclk);
    rc(port_sfmux_pkg::DAT0_IDX, 4'hf);
    for (int c = 0; c < 4; c++) begin
      wr(port_sfmux_pkg::CLKOUT_CTRL_IDX, 4'(8 + c));
      rises(0, W, n);
      near(n, int'(W * 4 / per[c]), 2);
    end
    rises(4, 500, n);
    near(n, int'(500 * 4 / FAST), 2);
    wr(port_sfmux_pkg::TIMER_OUT_IDX, 4'h4);
    rises(1, W, n);
    near(n, int'(W * 4 / TMR), 2);
    wr(port_sfmux_pkg::TIMER_OUT_IDX, 4'h0);
    wr(port_sfmux_pkg::CLKOUT_CTRL_IDX, 4'h2);
    rises(1, 200, n);
    chk(32'({n[7:0], out_bit2_pin_o, out_bit3_pin_o, clkout_signal}), 32'h7);
    out_bit3_data <= 1'b0;
    out_bit3_float <= 1'b1;
    out_bit2_float <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'({out_bit3_pin_o, out_bit3_pin_oe, out_bit2_pin_oe}), 32'h0);
    out_bit3_data <= 1'b1;
    out_bit3_float <= 1'b0;
    out_bit2_float <= 1'b0;
    wr(port_sfmux_pkg::DIR1_IDX, 4'h8);
    wr(port_sfmux_pkg::DAT1_IDX, 4'h8);
    wr(port_sfmux_pkg::PUL1_IDX, 4'hf);
    serial_select <= 1'b1;
    repeat (8) begin
      @(posedge pclk);
      serial_clock_o <= ~serial_clock_o;
      serial_data_out <= serial_clock_o;
    end
    chk(32'({bidir_pin_oe[7:4], bidir_pin_o[7], bidir_pullup_en[7:4]}), 32'h1d1);
    serial_slave <= 1'b1;
    ext_en <= 12'h050;
    ext_val <= 12'h050;
    repeat (6) begin
      @(posedge pclk);
      serial_ready_out <= ~serial_ready_out;
    end
    chk(32'({serial_data_in, serial_clock_i, bidir_pullup_en[7:4]}), 32'h35);
    ext_val <= 12'h0;
    repeat (6) @(posedge pclk);
    chk(32'({serial_data_in, serial_clock_i}), 32'h0);
    serial_select <= 1'b0;
    wr(port_sfmux_pkg::DIR2_IDX, 4'h0);
    repeat (3) @(posedge pclk);
    chk(32'(bidir_pin_oe[11:10]), 32'h3);
    for (int d = 0; d < 3; d++) begin
      lcd_duty <= 2'(d);
      lh = (d == 0) ? 32 : 16;
      fl = (d == 0) ? 8 : (d == 1) ? 16 : 17;
      half(2, n);
      near(n, int'(lh * SLOW / 4), 6);
      half(3, n);
      near(n, int'(fl * lh * 2 * SLOW / 4), 8);
    end
    apb(16'hff50, 1'b1, 4'hf, rd, er);
    apb(16'hff50, 1'b0, 4'h0, rd, er);
    chk({rd[30:0], er}, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) rc(rows[i].idx, rows[i].rs);
    chk(32'({bidir_pin_oe, bidir_pullup_en}), 32'hfff);
    results();
  end
endmodule
`default_nettype wire
